// *** sim/ctm_pin_partner.sv ***
// Count pin source and output pin load facing the compact timer
`timescale 1ns/1ns
`default_nettype none

module ctm_pin_partner (
    // Clock
    input  wire logic       clk_sys,
    // Command
    input  wire logic       start,
    input  wire logic [7:0] n_pulses,
    output logic            busy,
    // Pins
    output logic            ext_pin,
    input  wire logic       out_pin,
    output logic [7:0]      out_toggles
);
    logic [7:0] left_r;
    logic [2:0] ph_r;
    logic       out_q;

    initial begin
        busy = 1'b0;
        ext_pin = 1'b0;
        out_toggles = 8'h00;
        left_r = 8'h00;
        ph_r = 3'h0;
        out_q = 1'b0;
    end

    // Pin stands low between bursts; pulses are 3 high, 3 low
    always @(posedge clk_sys) begin
        out_q <= out_pin;
        if (out_q !== out_pin) begin
            out_toggles <= out_toggles + 8'h01;
        end
        if (start && !busy) begin
            left_r <= n_pulses;
            ph_r <= 3'h0;
            busy <= (n_pulses != 8'h00);
        end else if (busy) begin
            ext_pin <= (ph_r < 3'h3);
            ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
            if (ph_r == 3'h5) begin
                left_r <= left_r - 8'h01;
                busy <= (left_r != 8'h01);
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_ctm_top.sv ***
// Self-checking bench of the compact timer
`timescale 1ns/1ns
`default_nettype none
`include "ctm_consts.svh"

module tb_ctm_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hclk_tick = 1'b0;
    logic        sub_tick = 1'b0;
    logic [2:0]  sub_div = 3'h0;
    logic        ext_pin;
    logic        out_pin;
    logic        irq_a;
    logic        irq_p;
    logic        ack_a = 1'b0;
    logic        ack_p = 1'b0;
    logic        ce = 1'b1;
    logic        p_start = 1'b0;
    logic [7:0]  p_n = 8'h00;
    logic        p_busy;
    logic [7:0]  p_tog;
    logic [31:0] rv;
    logic        re;
    logic [15:0] v16;
    logic [15:0] w16;
    int          num_errors = 0;
    int          checks_done = 0;

    always #4 clk_sys = ~clk_sys;
    // Slow internal ticks drive the prescaled inputs; no test selects them as count clock
    always @(posedge clk_sys) begin
        hclk_tick <= ~hclk_tick;
        sub_div <= sub_div + 3'h1;
        sub_tick <= (sub_div == 3'h7);
    end

    ctm_top i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hclk_tick(hclk_tick), .sub_tick(sub_tick),
        .external_count_pin(ext_pin), .timer_output_pin(out_pin),
        .irq_match_a(irq_a), .irq_match_p(irq_p),
        .irq_ack_a(ack_a), .irq_ack_p(ack_p));

    ctm_pin_partner i_pins (.clk_sys(clk_sys), .start(p_start),
        .n_pulses(p_n), .busy(p_busy), .ext_pin(ext_pin),
        .out_pin(out_pin), .out_toggles(p_tog));

    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            num_errors++;
            close_out();
        end
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // High byte first, then the buffered low byte
    task automatic rd16(input logic [11:0] hi, input logic [11:0] lo);
        apb(1'b0, hi, 32'h0);
        v16[15:8] = rv[7:0];
        apb(1'b0, lo, 32'h0);
        v16[7:0] = rv[7:0];
    endtask

    // Flag 0 partner busy, 1 match A request, 2 match P request
    task automatic wait_flag(input int sel, input logic lvl);
        int i;
        logic f;
        for (i = 0; i < 2000; i++) begin
            f = (sel == 0) ? p_busy : ((sel == 1) ? irq_a : irq_p);
            if (f === lvl) break;
            @(posedge clk_sys);
        end
        if (i == 2000) begin
            num_errors++;
            close_out();
        end
    endtask

    task automatic t_reset_map;
        apb(1'b0, `CTM_OFF_CTRL0, 32'h0);
        chk("ctrl0", rv, 32'h0);
        apb(1'b0, `CTM_OFF_CTRL1, 32'h0);
        chk("ctrl1", rv, 32'h0);
        apb(1'b0, `CTM_OFF_CMPP, 32'h0);
        chk("cmpp", rv, 32'h0);
        apb(1'b1, `CTM_OFF_CNT_HI, 32'h55);
        rd16(`CTM_OFF_CNT_HI, `CTM_OFF_CNT_LO);
        chk("count ro", v16, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", re, 1'b1);
        chk("unmapped data", rv, 32'h0);
    endtask

    task automatic t_cmpa_buffer;
        apb(1'b1, `CTM_OFF_CMPA_LO, 32'h34);
        rd16(`CTM_OFF_CMPA_HI, `CTM_OFF_CMPA_LO);
        chk("cmpa low kept", v16, 32'h0);
        apb(1'b1, `CTM_OFF_CMPA_LO, 32'h34);
        apb(1'b1, `CTM_OFF_CMPA_HI, 32'h12);
        rd16(`CTM_OFF_CMPA_HI, `CTM_OFF_CMPA_LO);
        chk("cmpa pair", v16, 32'h1234);
    endtask

    task automatic t_ext_edges;
        apb(1'b1, `CTM_OFF_CTRL0, 32'h68);
        p_start <= 1'b1;
        p_n <= 8'h05;
        @(posedge clk_sys);
        p_start <= 1'b0;
        @(posedge clk_sys);
        wait_flag(0, 1'b1);
        wait_flag(0, 1'b0);
        rd16(`CTM_OFF_CNT_HI, `CTM_OFF_CNT_LO);
        chk("rise count", v16, 32'h5);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h78);
        p_start <= 1'b1;
        p_n <= 8'h03;
        @(posedge clk_sys);
        p_start <= 1'b0;
        @(posedge clk_sys);
        wait_flag(0, 1'b0);
        rd16(`CTM_OFF_CNT_HI, `CTM_OFF_CNT_LO);
        chk("fall count", v16, 32'h8);
        chk("pin idle", out_pin, 1'b0);
    endtask

    task automatic t_match_a;
        logic [7:0] t0;
        apb(1'b1, `CTM_OFF_CTRL0, 32'h00);
        apb(1'b1, `CTM_OFF_CMPA_LO, 32'h10);
        apb(1'b1, `CTM_OFF_CMPA_HI, 32'h00);
        apb(1'b1, `CTM_OFF_CTRL1, 32'h31);
        t0 = p_tog;
        apb(1'b1, `CTM_OFF_CTRL0, 32'h18);
        wait_flag(1, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk("pin toggled", out_pin, 1'b1);
        chk("toggles", p_tog, t0 + 8'h01);
        rd16(`CTM_OFF_CNT_HI, `CTM_OFF_CNT_LO);
        chk("cleared by a", v16 <= 16'h0010, 1'b1);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h00);
        chk("a pending", irq_a, 1'b1);
        ack_a <= 1'b1;
        @(posedge clk_sys);
        ack_a <= 1'b0;
        @(posedge clk_sys);
        chk("a acked", irq_a, 1'b0);
    endtask

    task automatic t_match_p_pause;
        apb(1'b1, `CTM_OFF_CMPP, 32'h01);
        apb(1'b1, `CTM_OFF_CTRL1, 32'h00);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h18);
        wait_flag(2, 1'b1);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h98);
        rd16(`CTM_OFF_CNT_HI, `CTM_OFF_CNT_LO);
        chk("cleared by p", v16 < 16'h0100, 1'b1);
        w16 = v16;
        repeat (20) @(posedge clk_sys);
        rd16(`CTM_OFF_CNT_HI, `CTM_OFF_CNT_LO);
        chk("paused", v16, w16);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h18);
        // Clock enable low must freeze the running counter too
        ce <= 1'b0;
        repeat (20) @(posedge clk_sys);
        ce <= 1'b1;
        rd16(`CTM_OFF_CNT_HI, `CTM_OFF_CNT_LO);
        chk("resumed", v16, w16 + 16'h1);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h00);
        apb(1'b0, `CTM_OFF_PEND, 32'h0);
        chk("p flag", rv[1], 1'b1);
        apb(1'b1, `CTM_OFF_PEND, 32'h2);
        apb(1'b0, `CTM_OFF_PEND, 32'h0);
        chk("p cleared", rv[1], 1'b0);
        chk("p irq", irq_p, 1'b0);
    endtask

    // PWM wave with duty from compare A, then inverted set-high compare
    task automatic t_pwm_pol;
        apb(1'b1, `CTM_OFF_CTRL1, 32'ha8);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h18);
        repeat (4) @(posedge clk_sys);
        chk("pwm active", out_pin, 1'b1);
        repeat (20) @(posedge clk_sys);
        chk("pwm inactive", out_pin, 1'b0);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h00);
        apb(1'b1, `CTM_OFF_CTRL1, 32'h25);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h18);
        repeat (4) @(posedge clk_sys);
        chk("pin initial inv", out_pin, 1'b1);
        repeat (20) @(posedge clk_sys);
        chk("pin high inv", out_pin, 1'b0);
        apb(1'b1, `CTM_OFF_CTRL0, 32'h00);
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_map();
        t_cmpa_buffer();
        t_ext_edges();
        t_match_a();
        t_match_p_pause();
        t_pwm_pol();
        close_out();
    end
endmodule
`default_nettype wire

// *** verilog/ctm_clk_sel.sv ***
// Count clock source selection and prescaling for the compact timer
`timescale 1ns/1ns
`default_nettype none
`include "ctm_consts.svh"

module ctm_clk_sel (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] clk_sel,
    // Tick sources
    input  wire logic       hclk_tick,
    input  wire logic       sub_tick,
    input  wire logic       ext_pin,
    // Result
    output logic            count_tick
);

    logic [1:0] div4_r;
    logic [5:0] hdiv_r;
    logic       ext_prev_r;
    logic       src_tick;

    wire sys4_tick = (div4_r == `CTM_DIV4_LAST);
    wire h16_tick  = hclk_tick & (hdiv_r[3:0] == `CTM_DIV16_LAST);
    wire h64_tick  = hclk_tick & (hdiv_r == `CTM_DIV64_LAST);
    wire ext_rise  = ext_pin & ~ext_prev_r;
    wire ext_fall  = ~ext_pin & ext_prev_r;

    // Prescalers run free so a source switch needs no restart
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div4_r     <= '0;
            hdiv_r     <= '0;
            ext_prev_r <= 1'b0;
        end else if (ce) begin
            div4_r     <= div4_r + 2'h1;
            if (hclk_tick) begin
                hdiv_r <= hdiv_r + 6'h1;
            end
            ext_prev_r <= ext_pin;
        end
    end

    always_comb begin
        case (ctm_pkg::ctm_clksel_t'(clk_sel))
            ctm_pkg::CTM_CK_SYS4:     src_tick = sys4_tick;
            ctm_pkg::CTM_CK_SYS:      src_tick = 1'b1;
            ctm_pkg::CTM_CK_H16:      src_tick = h16_tick;
            ctm_pkg::CTM_CK_H64:      src_tick = h64_tick;
            ctm_pkg::CTM_CK_SUB0:     src_tick = sub_tick;
            ctm_pkg::CTM_CK_SUB1:     src_tick = sub_tick;
            ctm_pkg::CTM_CK_EXT_RISE: src_tick = ext_rise;
            ctm_pkg::CTM_CK_EXT_FALL: src_tick = ext_fall;
            default:                  src_tick = 1'b0;
        endcase
    end

    assign count_tick = src_tick & run & ce;

endmodule
`default_nettype wire

// *** verilog/ctm_consts.svh ***
// Register offsets, field positions and fixed values of the compact timer
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define CTM_OFF_CTRL0     12'h000
`define CTM_OFF_CTRL1     12'h004
`define CTM_OFF_CNT_LO    12'h008
`define CTM_OFF_CNT_HI    12'h00c
`define CTM_OFF_CMPA_LO   12'h010
`define CTM_OFF_CMPA_HI   12'h014
`define CTM_OFF_CMPP      12'h018
`define CTM_OFF_PEND      12'h01c

// ***************************************************************
// Field positions
// ***************************************************************
`define CTM_C0_PAUSE      7
`define CTM_C0_CKS_HI     6
`define CTM_C0_CKS_LO     4
`define CTM_C0_ON         3
`define CTM_C0_MASK       8'hf8
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_IO_HI      5
`define CTM_C1_IO_LO      4
`define CTM_C1_OC         3
`define CTM_C1_POL        2
`define CTM_C1_DPX        1
`define CTM_C1_CCLR       0
`define CTM_PEND_A        0
`define CTM_PEND_P        1

// ***************************************************************
// Values
// ***************************************************************
`define CTM_RST_BYTE      8'h00
`define CTM_RST_WORD      16'h0000
`define CTM_CNT_MAX       16'hffff
`define CTM_CNT_STEP      16'h0001
`define CTM_RDATA_PAD     24'h000000
`define CTM_PEND_PAD      6'h00
`define CTM_PIN_IDLE      1'b0
`define CTM_DIV4_LAST     2'h3
`define CTM_DIV16_LAST    4'hf
`define CTM_DIV64_LAST    6'h3f
`define CTM_IO_NONE       2'h0
`define CTM_IO_LOW        2'h1
`define CTM_IO_HIGH       2'h2
`define CTM_IO_TOGGLE     2'h3
`define CTM_PWM_INACT     2'h0
`define CTM_PWM_ACT       2'h1
`define CTM_PWM_WAVE      2'h2

`endif

// *** verilog/ctm_pkg.sv ***
// Types shared by the compact timer modules
`default_nettype none
package ctm_pkg;

    typedef enum logic [1:0] {
        CTM_MODE_CMP   = 2'b00,
        CTM_MODE_UNDEF = 2'b01,
        CTM_MODE_PWM   = 2'b10,
        CTM_MODE_TMR   = 2'b11
    } ctm_mode_t;

    typedef enum logic [2:0] {
        CTM_CK_SYS4     = 3'b000,
        CTM_CK_SYS      = 3'b001,
        CTM_CK_H16      = 3'b010,
        CTM_CK_H64      = 3'b011,
        CTM_CK_SUB0     = 3'b100,
        CTM_CK_SUB1     = 3'b101,
        CTM_CK_EXT_RISE = 3'b110,
        CTM_CK_EXT_FALL = 3'b111
    } ctm_clksel_t;

endpackage
`default_nettype wire

// *** verilog/ctm_top.sv ***
// Compact timer: 16-bit up counter, two comparators, APB register slave
//
// Overview of operation
// - A 16-bit counter counts only upward on each selected clock tick.
// - Comparator P matches its 8-bit value against counter bits 15..8.
// - Comparator A matches its 16-bit value against the whole counter.
// - Software cannot load the counter; enable rising edge clears it.
// - Counter clears itself on overflow or on the selected comparator match.
// - Separate interrupt requests for comparator A and comparator P matches.
// - Count clock from system ratios, high clock, sub clock or pin.
// - External pin counts on rising or falling edge as configured.
// - Compare mode sets, clears or toggles the output pin on match.
// - The same output pin carries the PWM waveform in PWM mode.
// - No capture input exists; the only input pin is the count pin.
// - Modes are compare output, timer/event counter and PWM output.
// - Low bytes pass through a shared buffer, moved on high byte access.
// - Writing compare A low byte only loads the holding buffer.
// - Writing compare A high byte also copies the buffer into low byte.
// - Reading a high byte captures the matching low byte into the buffer.
// - Counter pair read-only, compare A pair read/write, P separate.
// - Mode field: 00 compare, 01 undefined, 10 PWM, 11 timer.
// - Clock field decodes eight codes into seven sources including two pin edges.
// - Pause bit freezes the counter; clearing it resumes from there.
// - Clear select (DPX in PWM mode) picks A match, or P match and overflow when P zero.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ctm_consts.svh"

module ctm_top (
    // Clock, reset, clock enable
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Internal clock ticks
    input  wire logic        hclk_tick,
    input  wire logic        sub_tick,
    // Pins
    input  wire logic        external_count_pin,
    output logic             timer_output_pin,
    // Interrupt requests and acknowledges
    output logic             irq_match_a,
    output logic             irq_match_p,
    input  wire logic        irq_ack_a,
    input  wire logic        irq_ack_p
);

    // ***********************************************************
    // State
    // ***********************************************************
    logic [7:0]  ctrl0_r;
    logic [7:0]  ctrl1_r;
    logic [15:0] cnt_r;
    logic [15:0] cmpa_r;
    logic [7:0]  cmpp_r;
    logic [7:0]  buf_r;
    logic [1:0]  pend_r;
    logic        en_prev_r;
    logic        cmp_lvl_r;
    logic        pin_r;
    logic [7:0]  prdata_r;

    logic [15:0] cnt_nxt;
    logic [15:0] cmpa_nxt;
    logic [7:0]  buf_nxt;
    logic [1:0]  pend_nxt;
    logic        cmp_lvl_nxt;
    logic        pin_nxt;
    logic [7:0]  rd_mux;
    logic        io_lvl;
    logic        pwm_lvl;
    logic        tick;

    function automatic logic ctm_drive(input logic lvl, input logic inv);
        return lvl ^ inv;
    endfunction

    // ***********************************************************
    // APB decode
    // ***********************************************************
    wire acc_setup  = psel & ~penable;
    wire acc_done   = psel & penable;
    wire hit_c0     = (paddr == `CTM_OFF_CTRL0);
    wire hit_c1     = (paddr == `CTM_OFF_CTRL1);
    wire hit_cnt_lo = (paddr == `CTM_OFF_CNT_LO);
    wire hit_cnt_hi = (paddr == `CTM_OFF_CNT_HI);
    wire hit_a_lo   = (paddr == `CTM_OFF_CMPA_LO);
    wire hit_a_hi   = (paddr == `CTM_OFF_CMPA_HI);
    wire hit_p      = (paddr == `CTM_OFF_CMPP);
    wire hit_pend   = (paddr == `CTM_OFF_PEND);
    wire addr_ok    = hit_c0 | hit_c1 | hit_cnt_lo | hit_cnt_hi |
                      hit_a_lo | hit_a_hi | hit_p | hit_pend;
    wire wr         = ce & acc_done & pwrite;
    // Read side effects are taken at setup so high byte and low byte
    // capture see the same counter snapshot
    wire rd_setup   = ce & acc_setup & ~pwrite;

    assign pready  = 1'b1;
    assign pslverr = acc_done & ~addr_ok;
    assign prdata  = {`CTM_RDATA_PAD, prdata_r};

    // ***********************************************************
    // Control fields
    // ***********************************************************
    wire       en    = ctrl0_r[`CTM_C0_ON];
    wire       pause = ctrl0_r[`CTM_C0_PAUSE];
    wire [2:0] cks   = ctrl0_r[`CTM_C0_CKS_HI:`CTM_C0_CKS_LO];
    wire [1:0] io    = ctrl1_r[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
    wire       oc    = ctrl1_r[`CTM_C1_OC];
    wire       pol   = ctrl1_r[`CTM_C1_POL];
    wire       dpx   = ctrl1_r[`CTM_C1_DPX];
    wire       cclr  = ctrl1_r[`CTM_C1_CCLR];
    ctm_pkg::ctm_mode_t mode;
    assign mode = ctm_pkg::ctm_mode_t'(
                  ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);

    wire en_rise = ce & en & ~en_prev_r;
    wire run     = en & ~pause;

    // ***********************************************************
    // Count clock; the count pin is the only input, no capture
    // ***********************************************************
    ctm_clk_sel u_clk_sel (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .ce         (ce),
        .run        (run),
        .clk_sel    (cks),
        .hclk_tick  (hclk_tick),
        .sub_tick   (sub_tick),
        .ext_pin    (external_count_pin),
        .count_tick (tick)
    );

    // ***********************************************************
    // Comparators and counter
    // ***********************************************************
    wire p_zero = (cmpp_r == `CTM_RST_BYTE);
    wire a_eq   = (cnt_r == cmpa_r);
    // Upper bits match once per period at low byte zero; a zero period
    // value means the full 16-bit overflow instead
    wire p_eq   = p_zero ? (cnt_r == `CTM_CNT_MAX)
                         : ((cnt_r[15:8] == cmpp_r) &&
                            (cnt_r[7:0] == `CTM_RST_BYTE));
    wire a_hit  = tick & a_eq & ~en_rise;
    wire p_hit  = tick & p_eq & ~en_rise;
    wire clr    = (mode == ctm_pkg::CTM_MODE_PWM) ? (dpx ? a_hit : p_hit)
                                                  : (cclr ? a_hit : p_hit);

    wire [15:0] cnt_inc = cnt_r + `CTM_CNT_STEP;
    assign cnt_nxt = (en_rise | clr) ? `CTM_RST_WORD
                                     : (tick ? cnt_inc : cnt_r);

    // ***********************************************************
    // Byte buffer and compare A pair
    // ***********************************************************
    assign buf_nxt  = (wr & hit_a_lo)       ? pwdata[7:0] :
                      (rd_setup & hit_cnt_hi) ? cnt_r[7:0] :
                      (rd_setup & hit_a_hi) ? cmpa_r[7:0] :
                      buf_r;
    assign cmpa_nxt = (wr & hit_a_hi) ? {pwdata[7:0], buf_r}
                                      : cmpa_r;

    always_comb begin
        rd_mux = `CTM_RST_BYTE;
        if (hit_c0) begin
            rd_mux = ctrl0_r;
        end else if (hit_c1) begin
            rd_mux = ctrl1_r;
        end else if (hit_cnt_lo | hit_a_lo) begin
            rd_mux = buf_r;
        end else if (hit_cnt_hi) begin
            rd_mux = cnt_r[15:8];
        end else if (hit_a_hi) begin
            rd_mux = cmpa_r[15:8];
        end else if (hit_p) begin
            rd_mux = cmpp_r;
        end else if (hit_pend) begin
            rd_mux = {`CTM_PEND_PAD, pend_r};
        end
    end

    // ***********************************************************
    // Pending match requests; a new match beats a same-cycle clear
    // ***********************************************************
    wire clr_pa = (wr & hit_pend & pwdata[`CTM_PEND_A]) | irq_ack_a;
    wire clr_pp = (wr & hit_pend & pwdata[`CTM_PEND_P]) | irq_ack_p;
    assign pend_nxt[`CTM_PEND_A] = a_hit |
                                   (pend_r[`CTM_PEND_A] & ~clr_pa);
    assign pend_nxt[`CTM_PEND_P] = p_hit |
                                   (pend_r[`CTM_PEND_P] & ~clr_pp);
    assign irq_match_a = pend_r[`CTM_PEND_A];
    assign irq_match_p = pend_r[`CTM_PEND_P];

    // ***********************************************************
    // Output pin
    // ***********************************************************
    always_comb begin
        case (io)
            `CTM_IO_NONE: io_lvl = cmp_lvl_r;
            `CTM_IO_LOW:  io_lvl = 1'b0;
            `CTM_IO_HIGH: io_lvl = 1'b1;
            default:      io_lvl = ~cmp_lvl_r;
        endcase
    end

    assign cmp_lvl_nxt = en_rise ? oc :
                         (a_hit & (mode == ctm_pkg::CTM_MODE_CMP)) ? io_lvl :
                         cmp_lvl_r;

    wire [15:0] duty       = dpx ? {cmpp_r, `CTM_RST_BYTE} : cmpa_r;
    wire        pwm_active = (cnt_r < duty);

    always_comb begin
        case (io)
            `CTM_PWM_INACT: pwm_lvl = ~oc;
            `CTM_PWM_ACT:   pwm_lvl = oc;
            `CTM_PWM_WAVE:  pwm_lvl = pwm_active ? oc : ~oc;
            default:        pwm_lvl = ~oc;
        endcase
    end

    always_comb begin
        case (mode)
            ctm_pkg::CTM_MODE_CMP: pin_nxt = ctm_drive(cmp_lvl_nxt, pol);
            ctm_pkg::CTM_MODE_PWM: pin_nxt = ctm_drive(pwm_lvl, pol);
            default:               pin_nxt = `CTM_PIN_IDLE;
        endcase
    end

    assign timer_output_pin = pin_r;

    // ***********************************************************
    // Registers
    // ***********************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl0_r   <= `CTM_RST_BYTE;
            ctrl1_r   <= `CTM_RST_BYTE;
            cmpp_r    <= `CTM_RST_BYTE;
            prdata_r  <= `CTM_RST_BYTE;
        end else if (ce) begin
            if (wr & hit_c0) begin
                ctrl0_r <= pwdata[7:0] & `CTM_C0_MASK;
            end
            if (wr & hit_c1) begin
                ctrl1_r <= pwdata[7:0];
            end
            if (wr & hit_p) begin
                cmpp_r <= pwdata[7:0];
            end
            if (rd_setup) begin
                prdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r     <= `CTM_RST_WORD;
            cmpa_r    <= `CTM_RST_WORD;
            buf_r     <= `CTM_RST_BYTE;
            pend_r    <= '0;
            en_prev_r <= 1'b0;
            cmp_lvl_r <= 1'b0;
            pin_r     <= `CTM_PIN_IDLE;
        end else if (ce) begin
            cnt_r     <= cnt_nxt;
            cmpa_r    <= cmpa_nxt;
            buf_r     <= buf_nxt;
            pend_r    <= pend_nxt;
            en_prev_r <= en;
            cmp_lvl_r <= cmp_lvl_nxt;
            pin_r     <= pin_nxt;
        end
    end

    // ***********************************************************
    // Assertions
    // ***********************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_en_clear;
        en_rise |=> (cnt_r == `CTM_RST_WORD);
    endproperty
    a_en_clear: assert property (p_en_clear)
        else $error("counter not cleared after enable");

    property p_count_up;
        (tick && !en_rise && !clr) |=> (cnt_r == 16'($past(cnt_r) + 16'h1));
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not advance by one");

    property p_pause_hold;
        (ce && en && pause && !en_rise) |=> $stable(cnt_r);
    endproperty
    a_pause_hold: assert property (p_pause_hold)
        else $error("counter moved while paused");

    property p_match_clear;
        (ce && clr && !en_rise) |=> (cnt_r == `CTM_RST_WORD);
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("counter not cleared on match");

    property p_pend_set;
        (a_hit ##1 !clr_pa) |=> pend_r[`CTM_PEND_A] && irq_match_a;
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("match A request missing");

    property p_pend_hold;
        (pend_r[`CTM_PEND_P] && !clr_pp) |=> pend_r[`CTM_PEND_P];
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("pending P request dropped");

    property p_lo_write;
        (wr && hit_a_lo) |=> $stable(cmpa_r) &&
                             (buf_r == $past(pwdata[7:0]));
    endproperty
    a_lo_write: assert property (p_lo_write)
        else $error("low byte write reached comparator");

    property p_hi_write;
        (wr && hit_a_hi) |=> (cmpa_r == {$past(pwdata[7:0]), $past(buf_r)});
    endproperty
    a_hi_write: assert property (p_hi_write)
        else $error("high byte write did not merge buffer");

    property p_hi_read;
        (rd_setup && hit_cnt_hi) |=> (buf_r == $past(cnt_r[7:0])) &&
                                     (prdata_r == $past(cnt_r[15:8]));
    endproperty
    a_hi_read: assert property (p_hi_read)
        else $error("high byte read did not capture low byte");

    property p_cmp_high;
        (a_hit && mode == ctm_pkg::CTM_MODE_CMP && io == `CTM_IO_HIGH)
            |=> (timer_output_pin == !pol);
    endproperty
    a_cmp_high: assert property (p_cmp_high)
        else $error("output pin not driven high on match");

    c_match_a:   cover property (a_hit && mode == ctm_pkg::CTM_MODE_CMP);
    c_pwm_p:     cover property (p_hit && mode == ctm_pkg::CTM_MODE_PWM);
    c_overflow:  cover property (p_hit && p_zero);
    c_hi_lo_rd:  cover property ((rd_setup && hit_cnt_hi) ##[1:4]
                                 (rd_setup && hit_cnt_lo));

endmodule
`default_nettype wire
